//--- rtl/nhp_oneshot.sv
/*
  retriggerable one-shot driving an active-low indicator.
  assumes the trigger is a one-cycle pulse from logic on the same clock.
*/
`default_nettype none

module nhp_oneshot #(
  parameter int unsigned PULSE_LEN = nhp_pkg::PULSE_CYCLES
) (
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  input  wire logic i_trigger,
  output logic      o_low_n
);
  import nhp_pkg::*;

  logic [PULSE_W-1:0] remain;

  // ---------------------------------------------------------------
  // countdown, reloaded by every trigger
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      remain  <= '0;
      o_low_n <= 1'b1;
    end else if (i_trigger) begin
      remain  <= PULSE_W'(PULSE_LEN - 1);
      o_low_n <= 1'b0;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end else begin
      o_low_n <= 1'b1;
    end
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  a_pulse_start: assert property (i_trigger |=> !o_low_n ##1 !o_low_n)
    else $error("indicator did not go low on trigger");
  a_pulse_hold: assert property ((!o_low_n && remain != '0) |=> !o_low_n)
    else $error("indicator released early");
  a_pulse_end: assert property ($rose(o_low_n) |-> $past(remain) == '0
                                && !$past(i_trigger))
    else $error("indicator released with time left");
endmodule // nhp_oneshot

`default_nettype wire

//--- rtl/nhp_pkg.sv
/*
  constants for the network health and probe block: register map, field positions, reset
  values and the indicator pulse length.
  assumes a 20 MHz driving clock that is also the register bus clock.
*/
//
// Notes on behaviour
// - a detected jammer sets the jammer flag, bit 9 of the status register.
// - writing one to the jammer flag clears it; later detections set it again.
// - jammer interrupt fires only when the flag goes from zero to one.
// - each dead link drives the link-loss indicator low, whatever the group register.
// - dead links counted in bits 0 to 7, saturating at 255.
// - writing one to bit 0 clears the dead-link count.
// - link-loss low pulse lasts at least 2505728 clocks and is retriggerable.
// - a resize that drops an established link also makes a dead-link event.
// - three consecutive dead links of one member make a member-decrease event.
// - each member decrease drives the member-loss indicator low.
// - member decreases counted in bits 8 to 15, saturating at 255.
// - writing one to bit 8 clears the member-decrease count.
// - member-loss low pulse lasts at least 2505728 clocks, retriggerable.
// - a resize that drops a station whose member flag is set also makes a member decrease.
// - a link established more than three times in a row sets the member flag.
// - stable-link output is low while any other station's member flag is set.
// - a probe command is issued only during the run phase.
// - probe level is high after reset, low on probe receipt, high on others.
// - the probe level can be routed to either utility output.
// - probe receipt raises an interrupt trigger when enabled.
// - software writes target and bit 7; bit 7 clears once the probe is sent.
`default_nettype none

package nhp_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CARE      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_QUERY     = 8'h08;
  localparam logic [7:0] OFS_UTIL      = 8'h0c;
  localparam logic [7:0] OFS_ENABLE    = 8'h10;
  localparam logic [7:0] OFS_MEMBER_LO = 8'h14;
  localparam logic [7:0] OFS_MEMBER_HI = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LINK_CLR_BIT   = 0;
  localparam int MEMBER_CLR_BIT = 8;
  localparam int JAMMER_BIT     = 9;
  localparam int PING_BIT       = 7;
  localparam int TS_W           = 6;
  localparam int UTIL_A_BIT     = 0;
  localparam int UTIL_B_BIT     = 1;
  localparam int EN_PING_BIT    = 0;
  localparam int EN_JAM_BIT     = 1;
  localparam int STATIONS       = 64;

  // ---------------------------------------------------------------
  // reset values and limits
  // ---------------------------------------------------------------
  localparam logic [7:0] COUNT_MAX    = 8'hff;
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [5:0] TARGET_RESET = 6'h00;
  localparam logic [1:0] UTIL_RESET   = 2'h0;
  localparam logic [1:0] ENABLE_RESET = 2'h0;
  localparam logic [1:0] EST_LIMIT    = 2'h3;
  localparam logic [1:0] DEAD_LIMIT   = 2'h2;

  // ---------------------------------------------------------------
  // indicator pulse timing
  // ---------------------------------------------------------------
  localparam int unsigned MCLK_HZ       = 20_000_000;
  localparam int unsigned DRIVE_HZ      = 20_000_000;
  localparam int unsigned PULSE_PERIODS = 2505728;
  localparam int unsigned PULSE_CYCLES  = PULSE_PERIODS * (MCLK_HZ / DRIVE_HZ);
  localparam int          PULSE_W       = 22;
endpackage : nhp_pkg

`default_nettype wire

//--- rtl/nhp_sat_counter.sv
/*
  8-bit saturating event counter with a software clear.
  assumes increment and clear are one-cycle pulses on the same clock.
*/
`default_nettype none

module nhp_sat_counter (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_inc,
  input  wire logic       i_clear,
  output logic      [7:0] o_count
);
  import nhp_pkg::*;

  // ---------------------------------------------------------------
  // count, hold at the top, event with clear in one cycle leaves one
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_count <= COUNT_RESET;
    end else if (i_inc && i_clear) begin
      o_count <= 8'h01;
    end else if (i_clear) begin
      o_count <= COUNT_RESET;
    end else if (i_inc && o_count != COUNT_MAX) begin
      o_count <= o_count + 8'h01;
    end
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  a_count_sat: assert property ((o_count == COUNT_MAX && !i_clear) |=> o_count == COUNT_MAX)
    else $error("counter left its top value");
  a_count_step: assert property ((i_inc && !i_clear && o_count != COUNT_MAX)
                                 |=> o_count == $past(o_count) + 8'h01)
    else $error("counter missed an event");
  a_count_clear: assert property ((i_clear && !i_inc) |=> o_count == COUNT_RESET)
    else $error("counter not cleared");
endmodule // nhp_sat_counter

`default_nettype wire

//--- rtl/nhp_top.sv
/*
  network health and probe block: jammer flag, dead-link and member-decrease tracking,
  indicator pulses, event counters, stable-link output and probe command handling.
  assumes an APB master on i_mclk and a protocol engine on the same clock that
  delivers one-cycle event pulses with the station number they concern.
*/
// The implementer's own choices: the placing of the registers and register access over APB.
`default_nettype none

module nhp_top #(
  parameter int unsigned PULSE_LEN = nhp_pkg::PULSE_CYCLES
) (
  input  wire logic                    i_mclk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [7:0]              i_paddr,
  input  wire logic [31:0]             i_pwdata,
  output logic      [31:0]             o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  input  wire logic [nhp_pkg::TS_W-1:0] i_station_address,
  input  wire logic                    i_run_phase,
  input  wire logic                    i_jammer_detect,
  input  wire logic [nhp_pkg::TS_W-1:0] i_event_station,
  input  wire logic                    i_link_established,
  input  wire logic                    i_dead_link,
  input  wire logic                    i_resize_drop,
  input  wire logic                    i_ping_received,
  input  wire logic                    i_other_received,
  input  wire logic                    i_ping_sent,
  output logic                         o_ping_request,
  output logic      [nhp_pkg::TS_W-1:0] o_ping_target,
  output logic                         o_jammer_irq,
  output logic                         o_ping_irq,
  output logic                         o_link_loss_indicator_n,
  output logic                         o_member_loss_indicator_n,
  output logic                         o_stable_link_indicator_n,
  output logic                         o_utility_out_a,
  output logic                         o_utility_out_b
);
  import nhp_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic                     jammer_flag;
  logic [TS_W-1:0]          target_station_field;
  logic                     ping_pend;
  logic [1:0]               utility_pin_select_reg;
  logic [1:0]               event_enable;
  logic                     probe;
  logic [STATIONS-1:0]      member_flag_reg;
  logic [STATIONS-1:0]      link_up;
  logic [STATIONS-1:0][1:0] est_run;
  logic [STATIONS-1:0][1:0] dead_run;
  logic [7:0]               link_loss_count;
  logic [7:0]               member_loss_count;

  logic                     setup;
  logic                     commit_wr;
  logic                     next_ping_pend;
  logic [TS_W-1:0]          next_target;
  logic                     dead_link_event;
  logic                     member_decrease_event;
  logic                     clr_link;
  logic                     clr_member;
  logic [STATIONS-1:0]      other_members;
  logic [31:0]              read_mux;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] addr);
    case (addr)
      OFS_CARE, OFS_STATUS, OFS_QUERY, OFS_UTIL,
      OFS_ENABLE, OFS_MEMBER_LO, OFS_MEMBER_HI: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
                                  input logic [7:0] ofs);
    wr_hit = wr && (addr == ofs);
  endfunction

  // setup phase and the write that completes the access phase
  assign setup     = i_psel && !i_penable;
  assign commit_wr = i_psel && i_penable && o_pready && i_pwrite;

  // care register clear strobes, only set bits act
  assign clr_link   = wr_hit(commit_wr, i_paddr, OFS_CARE) && i_pwdata[LINK_CLR_BIT];
  assign clr_member = wr_hit(commit_wr, i_paddr, OFS_CARE) && i_pwdata[MEMBER_CLR_BIT];

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_comb begin
    read_mux = 32'h0000_0000;
    case (i_paddr)
      OFS_CARE:      read_mux[15:0] = {member_loss_count, link_loss_count};
      OFS_STATUS:    read_mux[JAMMER_BIT] = jammer_flag;
      OFS_QUERY: begin
        read_mux[TS_W-1:0] = target_station_field;
        read_mux[PING_BIT] = ping_pend;
      end
      OFS_UTIL:      read_mux[1:0] = utility_pin_select_reg;
      OFS_ENABLE:    read_mux[1:0] = event_enable;
      OFS_MEMBER_LO: read_mux = member_flag_reg[31:0];
      OFS_MEMBER_HI: read_mux = member_flag_reg[63:32];
      default:       read_mux = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // apb slave: no wait states, answer registered at setup
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup && !is_mapped(i_paddr);
      if (setup) begin
        o_prdata <= i_pwrite ? 32'h0000_0000 : read_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // jammer flag and its interrupt trigger
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      jammer_flag  <= 1'b0;
      o_jammer_irq <= 1'b0;
    end else begin
      if (i_jammer_detect) begin
        jammer_flag <= 1'b1;
      end else if (wr_hit(commit_wr, i_paddr, OFS_STATUS) && i_pwdata[JAMMER_BIT]) begin
        jammer_flag <= 1'b0;
      end
      // only the zero-to-one step of the flag raises the trigger
      o_jammer_irq <= i_jammer_detect && !jammer_flag && event_enable[EN_JAM_BIT];
    end
  end

  // ---------------------------------------------------------------
  // control registers of the utility pins and event enables
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      utility_pin_select_reg <= UTIL_RESET;
      event_enable           <= ENABLE_RESET;
    end else begin
      if (wr_hit(commit_wr, i_paddr, OFS_UTIL)) begin
        utility_pin_select_reg <= i_pwdata[1:0];
      end
      if (wr_hit(commit_wr, i_paddr, OFS_ENABLE)) begin
        event_enable <= i_pwdata[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // probe command: software request, cleared once sent
  // ---------------------------------------------------------------
  always_comb begin
    next_ping_pend = ping_pend;
    next_target    = target_station_field;
    if (wr_hit(commit_wr, i_paddr, OFS_QUERY)) begin
      next_ping_pend = i_pwdata[PING_BIT];
      next_target    = i_pwdata[TS_W-1:0];
    end else if (i_ping_sent) begin
      next_ping_pend = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ping_pend            <= 1'b0;
      target_station_field <= TARGET_RESET;
      o_ping_request       <= 1'b0;
      o_ping_target        <= TARGET_RESET;
    end else begin
      ping_pend            <= next_ping_pend;
      target_station_field <= next_target;
      // a pending request waits outside the run phase
      o_ping_request       <= next_ping_pend && i_run_phase;
      o_ping_target        <= next_target;
    end
  end

  // ---------------------------------------------------------------
  // received probe level, its routing and its interrupt trigger
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      probe      <= 1'b1;
      o_ping_irq <= 1'b0;
    end else begin
      if (i_ping_received) begin
        probe <= 1'b0;
      end else if (i_other_received) begin
        probe <= 1'b1;
      end
      o_ping_irq <= i_ping_received && event_enable[EN_PING_BIT];
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_utility_out_a <= 1'b1;
      o_utility_out_b <= 1'b1;
    end else begin
      // unselected pins idle high
      o_utility_out_a <= !utility_pin_select_reg[UTIL_A_BIT] || probe;
      o_utility_out_b <= !utility_pin_select_reg[UTIL_B_BIT] || probe;
    end
  end

  // ---------------------------------------------------------------
  // event decode for the reported station
  // ---------------------------------------------------------------
  always_comb begin
    dead_link_event       = 1'b0;
    member_decrease_event = 1'b0;
    if (i_resize_drop) begin
      dead_link_event       = link_up[i_event_station];
      member_decrease_event = member_flag_reg[i_event_station];
    end else if (i_dead_link) begin
      dead_link_event       = 1'b1;
      member_decrease_event = member_flag_reg[i_event_station]
                              && dead_run[i_event_station] == DEAD_LIMIT;
    end
  end

  // ---------------------------------------------------------------
  // per-station link history and member flags
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      member_flag_reg <= '0;
      link_up         <= '0;
      est_run         <= '0;
      dead_run        <= '0;
    end else if (i_resize_drop) begin
      member_flag_reg[i_event_station] <= 1'b0;
      link_up[i_event_station]         <= 1'b0;
      est_run[i_event_station]         <= 2'h0;
      dead_run[i_event_station]        <= 2'h0;
    end else if (i_dead_link) begin
      link_up[i_event_station] <= 1'b0;
      est_run[i_event_station] <= 2'h0;
      if (member_decrease_event) begin
        member_flag_reg[i_event_station] <= 1'b0;
        dead_run[i_event_station]        <= 2'h0;
      end else if (dead_run[i_event_station] != DEAD_LIMIT) begin
        dead_run[i_event_station] <= dead_run[i_event_station] + 2'h1;
      end
    end else if (i_link_established) begin
      link_up[i_event_station]  <= 1'b1;
      dead_run[i_event_station] <= 2'h0;
      if (est_run[i_event_station] == EST_LIMIT) begin
        member_flag_reg[i_event_station] <= 1'b1;
      end else begin
        est_run[i_event_station] <= est_run[i_event_station] + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // stable-link indicator, own station excluded
  // ---------------------------------------------------------------
  assign other_members = member_flag_reg
                         & ~(64'h0000_0000_0000_0001 << i_station_address);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_stable_link_indicator_n <= 1'b1;
    end else begin
      o_stable_link_indicator_n <= !(|other_members);
    end
  end

  // ---------------------------------------------------------------
  // indicator pulses and event counters
  // ---------------------------------------------------------------
  nhp_oneshot #(
    .PULSE_LEN (PULSE_LEN)
  ) u_link_pulse (
    .i_mclk    (i_mclk),
    .i_resetn  (i_resetn),
    .i_trigger (dead_link_event),
    .o_low_n   (o_link_loss_indicator_n)
  );

  nhp_oneshot #(
    .PULSE_LEN (PULSE_LEN)
  ) u_member_pulse (
    .i_mclk    (i_mclk),
    .i_resetn  (i_resetn),
    .i_trigger (member_decrease_event),
    .o_low_n   (o_member_loss_indicator_n)
  );

  nhp_sat_counter u_link_count (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_inc    (dead_link_event),
    .i_clear  (clr_link),
    .o_count  (link_loss_count)
  );

  nhp_sat_counter u_member_count (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_inc    (member_decrease_event),
    .i_clear  (clr_member),
    .o_count  (member_loss_count)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  a_jam_set: assert property (i_jammer_detect |=> jammer_flag)
    else $error("jammer flag not set");
  a_jam_clear: assert property ((wr_hit(commit_wr, i_paddr, OFS_STATUS)
                                 && i_pwdata[JAMMER_BIT] && !i_jammer_detect) |=> !jammer_flag)
    else $error("jammer flag not cleared");
  a_jam_irq_once: assert property (o_jammer_irq |-> jammer_flag && !$past(jammer_flag))
    else $error("jammer trigger without a rising flag");
  a_ping_in_run: assert property (o_ping_request |-> $past(i_run_phase) && ping_pend)
    else $error("probe requested outside run phase");
  a_ping_done: assert property ((i_ping_sent && !wr_hit(commit_wr, i_paddr, OFS_QUERY))
                                |=> !ping_pend && !o_ping_request)
    else $error("probe request not retired");
  a_probe_level: assert property (i_ping_received |=> !probe
                                  ##1 (!probe || $past(i_other_received)))
    else $error("probe level wrong after receipt");
  a_ping_irq_en: assert property ((i_ping_received && event_enable[EN_PING_BIT])
                                  |=> o_ping_irq)
    else $error("probe interrupt missing");
  a_stable_out: assert property (##1 o_stable_link_indicator_n
                                 == ($past(other_members) == '0))
    else $error("stable-link output wrong");
  a_member_drop: assert property ((i_dead_link && member_flag_reg[i_event_station]
                                   && dead_run[i_event_station] == DEAD_LIMIT)
                                  |=> !o_member_loss_indicator_n)
    else $error("member decrease missed");
  a_care_keep: assert property ((commit_wr && i_paddr == OFS_CARE
                                 && !i_pwdata[LINK_CLR_BIT] && !dead_link_event)
                                |=> link_loss_count == $past(link_loss_count))
    else $error("count changed by a zero write");
endmodule // nhp_top

`default_nettype wire

//--- testbench/network_health_and_ping_test.sv
/* self-checking bench for the health and probe block.
   assumes nhp_pkg, nhp_top and the peer model are compiled first. */
`default_nettype none
module network_health_and_ping_test;
  timeunit 1ns;
  timeprecision 1ns;
  import nhp_pkg::*;
  logic        mclk, resetn, psel, penable, pwrite, run, jam, est, dead, pingr, othr, drop;
  logic        sent, req, jirq, pirq, lnk_n, mem_n, stb_n, ua, ub, pready, pslverr, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  evst, ptgt, s, own;
  int          seed = 32'hffe4_a588;
  int          err_total, n_checks, n;
  nhp_top #(.PULSE_LEN(8)) u_nhp_top (.i_mclk(mclk), .i_resetn(resetn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_station_address(own),
    .i_run_phase(run), .i_jammer_detect(jam), .i_event_station(evst),
    .i_link_established(est), .i_dead_link(dead), .i_resize_drop(drop),
    .i_ping_received(pingr), .i_other_received(othr), .i_ping_sent(sent),
    .o_ping_request(req), .o_ping_target(ptgt), .o_jammer_irq(jirq), .o_ping_irq(pirq),
    .o_link_loss_indicator_n(lnk_n), .o_member_loss_indicator_n(mem_n),
    .o_stable_link_indicator_n(stb_n), .o_utility_out_a(ua), .o_utility_out_b(ub));
  nhp_peer_model u_nhp_peer_model (.i_mclk(mclk), .i_resetn(resetn),
    .i_ping_request(req), .o_ping_sent(sent));
  // expected care counts, saturating
  function logic [31:0] cnt(int m, int l);
    return {16'h0000, 8'(m > 255 ? 255 : m), 8'(l > 255 ? 255 : l)};
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      err_total++;
    end
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  // one-cycle event: 5 resize drop, 4 jammer, 3 establish, 2 dead, 1 probe, 0 other
  task ev(input int k);
    @(posedge mclk);
    evst <= s;
    {drop, jam, est, dead, pingr, othr} <= 6'h01 << k;
    @(posedge mclk);
    {drop, jam, est, dead, pingr, othr} <= 6'h00;
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    test_done;
  end
  initial begin
    {resetn, psel, penable, pwrite, run, jam, est, dead, pingr, othr, drop} = '0;
    {paddr, pwdata, evst, own} = '0;
    s = 6'h01 | 6'($random(seed));
    n = 251 + ($random(seed) & 7);
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    apb(0, OFS_CARE, 0);
    chk("care reset", 0, rd);
    apb(1, OFS_ENABLE, 3);
    ev(4);
    @(negedge mclk) chk("jam irq", 1, jirq);
    ev(4);
    @(negedge mclk) chk("jam irq again", 0, jirq);
    apb(0, OFS_STATUS, 0);
    chk("jam flag", 32'h0000_0200, rd);
    apb(1, OFS_STATUS, 32'h0000_0200);
    apb(0, OFS_STATUS, 0);
    chk("jam clear", 0, rd);
    repeat (4) ev(3);
    repeat (2) @(negedge mclk);
    chk("stable", 0, stb_n);
    repeat (2) ev(2);
    @(negedge mclk) chk("member early", 1, mem_n);
    ev(2);
    @(negedge mclk) chk("member low", 0, mem_n);
    chk("link low", 0, lnk_n);
    repeat (3) @(negedge mclk);
    ev(2);
    repeat (6) @(negedge mclk);
    chk("link retrig", 0, lnk_n);
    chk("member end", 1, mem_n);
    repeat (12) @(negedge mclk);
    chk("link end", 1, lnk_n);
    repeat (n) ev(2);
    apb(0, OFS_CARE, 0);
    chk("care sat", cnt(1, 4 + n), rd);
    apb(1, OFS_CARE, 32'h0000_fefe);
    apb(0, OFS_CARE, 0);
    chk("care keep", cnt(1, 255), rd);
    apb(1, OFS_CARE, 1);
    apb(0, OFS_CARE, 0);
    chk("link clr", cnt(1, 0), rd);
    apb(1, OFS_CARE, 32'h0000_0100);
    apb(0, OFS_CARE, 0);
    chk("member clr", 0, rd);
    repeat (4) ev(3);
    repeat (2) @(negedge mclk);
    chk("stable again", 0, stb_n);
    @(posedge mclk) own <= s;
    repeat (2) @(negedge mclk);
    chk("own station", 1, stb_n);
    ev(5);
    @(negedge mclk) chk("drop pulses", 0, {lnk_n, mem_n});
    apb(0, OFS_CARE, 0);
    chk("drop counts", cnt(1, 1), rd);
    apb(1, OFS_UTIL, 3);
    ev(1);
    @(negedge mclk) chk("ping irq", 1, pirq);
    @(negedge mclk) chk("util low", 0, {ua, ub});
    ev(0);
    repeat (2) @(negedge mclk);
    chk("util high", 3, {ua, ub});
    apb(1, OFS_QUERY, 32'h0000_0080 | s);
    repeat (4) @(negedge mclk);
    chk("no probe", 0, req);
    @(posedge mclk) run <= 1'b1;
    repeat (2) @(negedge mclk);
    chk("probe req", 1, req);
    chk("probe target", 32'(s), ptgt);
    repeat (6) @(negedge mclk);
    apb(0, OFS_QUERY, 0);
    chk("query done", 32'(s), rd);
    apb(0, 8'h40, 0);
    chk("unmapped", 1, rerr);
    test_done;
  end
endmodule // network_health_and_ping_test
`default_nettype wire

//--- testbench/nhp_peer_model.sv
/* peer station model: sends a pending probe.
   assumes the block's clock and reset. */
`default_nettype none
module nhp_peer_model (
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  input  wire logic i_ping_request,
  output logic      o_ping_sent
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_cnt;
  // one sent pulse after three pending cycles
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_cnt    <= 2'h0;
      o_ping_sent <= 1'b0;
    end else begin
      o_ping_sent <= i_ping_request && wait_cnt == 2'h2;
      wait_cnt    <= (i_ping_request && !o_ping_sent) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule // nhp_peer_model
`default_nettype wire
